/* rtl/plsp_top.sv */
// Parallel LED outputs for ports 7..4 with shared reset straps.
// Assumes LED status from the same clock; board pulls on strap pins pass two sync stages.
`timescale 1ns/100ps
module plsp_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [14:0] LED_ON,
    input wire logic [14:0] PIN_IN,
    output plsp_pkg::plsp_strap_t STRAPS,
    output logic [14:0] PIN_OUT,
    output logic [14:0] PIN_OE_N
);
    import plsp_pkg::*;

    logic [14:0] sync1_r;
    logic [14:0] sync2_r;
    plsp_state_t state_r, state_nxt;
    plsp_strap_t strap_r, strap_nxt;
    logic [14:0] pol_r, pol_nxt;
    logic [14:0] out_r, out_nxt;
    logic [14:0] oe_n_r, oe_n_nxt;

    // Straps come from board pulls, so two stages before use
    always_ff @(posedge CLK) begin
        sync1_r <= PIN_IN;
        sync2_r <= sync1_r;
    end

    always_comb begin
        state_nxt = state_r;
        strap_nxt = strap_r;
        pol_nxt = pol_r;
        if (state_r == PLSP_SAMPLE) begin
            // First cycle after release catches the settled strap level
            strap_nxt.low_power = sync2_r[P7_D];
            strap_nxt.eeprom_type = {sync2_r[P5_D], sync2_r[P5_C]};
            strap_nxt.loop_detect = sync2_r[P4_C];
            // Opposite of strap so the pull keeps the LED dark
            pol_nxt = (LED_HIGH_MASK & ~STRAP_MASK) | (STRAP_MASK & ~sync2_r);
            state_nxt = PLSP_RUN;
        end
    end

    always_comb begin
        out_nxt = out_r;
        oe_n_nxt = oe_n_r;
        case (state_r)
            PLSP_SAMPLE: begin
                // Strap pins stay released while sampling
                out_nxt = ~LED_HIGH_MASK & ~STRAP_MASK;
                oe_n_nxt = STRAP_MASK;
            end
            PLSP_RUN: begin
                // Active-high polarity bit drives the on level directly
                out_nxt = ~(LED_ON ^ pol_r);
                oe_n_nxt = 15'h0000;
            end
            default: begin
                out_nxt = out_r;
                oe_n_nxt = oe_n_r;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r <= PLSP_SAMPLE;
            strap_r <= {STRAP_RST, EE_RST, STRAP_RST};
            pol_r <= LED_HIGH_MASK & ~STRAP_MASK;
            out_r <= ~LED_HIGH_MASK & ~STRAP_MASK;
            oe_n_r <= STRAP_MASK;
        end else begin
            state_r <= state_nxt;
            strap_r <= strap_nxt;
            pol_r <= pol_nxt;
            out_r <= out_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign STRAPS = strap_r;
    assign PIN_OUT = out_r;
    assign PIN_OE_N = oe_n_r;

    property p_dedicated_pol;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P7_C] == $past(LED_ON[P7_C]))
            && (PIN_OUT[P7_A] == !$past(LED_ON[P7_A]));
    endproperty
    a_dedicated_pol: assert property (p_dedicated_pol) else $error("port 7 polarity wrong");

    property p_port6_pol;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P6_D] == $past(LED_ON[P6_D]))
            && (PIN_OUT[P6_C] == !$past(LED_ON[P6_C]));
    endproperty
    a_port6_pol: assert property (p_port6_pol) else $error("port 6 polarity wrong");

    property p_port54_pol;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P5_B] == !$past(LED_ON[P5_B]))
            && (PIN_OUT[P4_A] == !$past(LED_ON[P4_A]));
    endproperty
    a_port54_pol: assert property (p_port54_pol) else $error("port 5/4 polarity wrong");

    property p_shared_pol;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P4_C] == ($past(LED_ON[P4_C]) ^ strap_r.loop_detect));
    endproperty
    a_shared_pol: assert property (p_shared_pol) else $error("shared LED polarity wrong");

    property p_sample;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_SAMPLE) |=> (strap_r.low_power == $past(sync2_r[P7_D]))
            && (strap_r.loop_detect == $past(sync2_r[P4_C]));
    endproperty
    a_sample: assert property (p_sample) else $error("strap not sampled");

    property p_eeprom;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_SAMPLE) |=> (strap_r.eeprom_type == {$past(sync2_r[P5_D]), $past(sync2_r[P5_C])});
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("eeprom strap wrong");

    property p_hold;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> $stable(strap_r) && $stable(pol_r);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed after reset");

    property p_release;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_SAMPLE) |=> ##1 (PIN_OE_N == 15'h0000);
    endproperty
    a_release: assert property (p_release) else $error("shared pins not driven");

    property p_fixed;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |-> (pol_r[P5_C] == !strap_r.eeprom_type[0]);
    endproperty
    a_fixed: assert property (p_fixed) else $error("polarity not fixed at reset");

    // Dedicated pins lag LED status by one cycle, the output register
    property p_port7_low;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P7_B] == !$past(LED_ON[P7_B]));
    endproperty
    a_port7_low: assert property (p_port7_low) else $error("port 7 b not active low");

    property p_port6_low;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P6_A] == !$past(LED_ON[P6_A]))
            && (PIN_OUT[P6_B] == !$past(LED_ON[P6_B]));
    endproperty
    a_port6_low: assert property (p_port6_low) else $error("port 6 a/b not low");

    property p_port5_low;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P5_A] == !$past(LED_ON[P5_A]));
    endproperty
    a_port5_low: assert property (p_port5_low) else $error("port 5 a not active low");

    property p_port4_low;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P4_B] == !$past(LED_ON[P4_B]));
    endproperty
    a_port4_low: assert property (p_port4_low) else $error("port 4 b not active low");

    property p_loop_sample;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_SAMPLE) |=> (strap_r.loop_detect == $past(sync2_r[P4_C]));
    endproperty
    a_loop_sample: assert property (p_loop_sample) else $error("loop strap missed");

    // Shared pins invert only when the strap was pulled high
    property p_shared_p7;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OUT[P7_D] == ($past(LED_ON[P7_D]) ^ strap_r.low_power));
    endproperty
    a_shared_p7: assert property (p_shared_p7) else $error("port 7 d polarity");

    property p_shared_p5;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=>
            (PIN_OUT[P5_C] == ($past(LED_ON[P5_C]) ^ strap_r.eeprom_type[0]))
            && (PIN_OUT[P5_D] == ($past(LED_ON[P5_D]) ^ strap_r.eeprom_type[1]));
    endproperty
    a_shared_p5: assert property (p_shared_p5) else $error("port 5 c/d polarity");

    property p_hold_off;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_SAMPLE) |-> (PIN_OE_N == STRAP_MASK);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("strap pins not released");

    property p_stay_run;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (state_r == PLSP_RUN);
    endproperty
    a_stay_run: assert property (p_stay_run) else $error("left run state");

    property p_shared_fixed;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |-> (pol_r[P7_D] == !strap_r.low_power)
            && (pol_r[P4_C] == !strap_r.loop_detect);
    endproperty
    a_shared_fixed: assert property (p_shared_fixed) else $error("polarity not held");

    property p_drive_hold;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == PLSP_RUN) |=> (PIN_OE_N == 15'h0000);
    endproperty
    a_drive_hold: assert property (p_drive_hold) else $error("shared pins released");
endmodule : plsp_top

/* rtl/plsp_pkg.sv */
// Package for the parallel LED and strap pin block.
// Assumes one 50 MHz core clock and a synchronous active-low reset.
package plsp_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned N_LED = 15;
    // Bit positions of each indicator on the led vectors
    localparam int unsigned P7_A = 0;
    localparam int unsigned P7_B = 1;
    localparam int unsigned P7_C = 2;
    localparam int unsigned P7_D = 3;
    localparam int unsigned P6_A = 4;
    localparam int unsigned P6_B = 5;
    localparam int unsigned P6_C = 6;
    localparam int unsigned P6_D = 7;
    localparam int unsigned P5_A = 8;
    localparam int unsigned P5_B = 9;
    localparam int unsigned P5_C = 10;
    localparam int unsigned P5_D = 11;
    localparam int unsigned P4_A = 12;
    localparam int unsigned P4_B = 13;
    localparam int unsigned P4_C = 14;
    // 1 marks an active-high dedicated pin; strap pins are overridden
    localparam logic [14:0] LED_HIGH_MASK = 15'h0084;
    // 1 marks a pin shared with a strap
    localparam logic [14:0] STRAP_MASK = 15'h4c08;
    // Strap defaults before the first sample, matching internal pull-downs
    localparam logic STRAP_RST = 1'h0;
    localparam logic [1:0] EE_RST = 2'h0;

    typedef struct packed {
        logic low_power;
        logic [1:0] eeprom_type;
        logic loop_detect;
    } plsp_strap_t;

    typedef enum logic [1:0] {
        PLSP_SAMPLE = 2'b01,
        PLSP_RUN = 2'b10
    } plsp_state_t;
endpackage : plsp_pkg

/* tb/plsp_board.sv */
// Board model: LEDs plus strap pulls on the shared LED pins.
// Assumes active-low output enables coming from the device.
`timescale 1ns/100ps
module plsp_board (
    input wire logic [14:0] PIN_OUT,
    input wire logic [14:0] PIN_OE_N,
    input wire logic [14:0] PULL,
    output logic [14:0] PIN_IN
);
    // Released pin settles to its pull, driven pin shows the drive
    assign PIN_IN = (PIN_OE_N & PULL) | (~PIN_OE_N & PIN_OUT);
endmodule : plsp_board

/* tb/plsp_top_tb.sv */
// Bench for plsp_top: strap capture and LED polarity per port.
// Assumes the board model supplies strap levels while pins are released.
`timescale 1ns/100ps
module plsp_top_tb;
    import plsp_pkg::*;
    logic CLK = 1'h0;
    logic RST_N = 1'h0;
    logic [14:0] LED_ON = 15'h0000;
    logic [14:0] PULL = 15'h0000;
    logic [14:0] PIN_IN;
    logic [14:0] PIN_OUT;
    logic [14:0] PIN_OE_N;
    plsp_strap_t STRAPS;
    int errors = 0;
    int tests_run = 0;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
    initial forever #10 CLK = ~CLK;
    plsp_top DUT (.CLK(CLK), .RST_N(RST_N), .LED_ON(LED_ON), .PIN_IN(PIN_IN),
        .STRAPS(STRAPS), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N));
    plsp_board BRD (.PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PULL(PULL),
        .PIN_IN(PIN_IN));
    function automatic plsp_strap_t stv(logic [14:0] s);
        return '{s[P7_D], {s[P5_D], s[P5_C]}, s[P4_C]};
    endfunction : stv
    // Sample away from the edge so registered outputs have landed
    task automatic cyc(int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc
    task automatic test_done();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // Three reset edges: pins released at the first, pulls through both stages by the third
    task automatic t_strap(logic [14:0] s);
        @(posedge CLK);
        RST_N <= 1'h0;
        PULL <= s;
        cyc(2);
        `CHK(STRAPS, plsp_strap_t'(4'h0))
        `CHK(PIN_OE_N, STRAP_MASK)
        `CHK(PIN_OUT & ~STRAP_MASK, ~LED_HIGH_MASK & ~STRAP_MASK)
        @(posedge CLK);
        RST_N <= 1'h1;
        cyc(3);
        `CHK(STRAPS, stv(s))
        `CHK(PIN_OE_N, 15'h0000)
    endtask : t_strap
    // Driven pins can now differ from the pulls, so straps must not move
    task automatic t_led(logic [14:0] s, logic [14:0] v);
        logic [14:0] exp_out;
        exp_out = v ^ (~LED_HIGH_MASK & ~STRAP_MASK) ^ (s & STRAP_MASK);
        @(posedge CLK);
        LED_ON <= v;
        cyc(1);
        `CHK(PIN_OUT, exp_out)
        `CHK(STRAPS, stv(s))
    endtask : t_led
    initial begin
        logic [14:0] pat [4];
        pat = '{15'h0000, 15'h4c08, 15'h0408, 15'h4800};
        foreach (pat[i]) begin
            t_strap(pat[i]);
            t_led(pat[i], 15'h7fff);
            t_led(pat[i], 15'h0000);
            t_led(pat[i], 15'h2a5a);
        end
        test_done();
    end
    initial begin
        repeat (5000) @(posedge CLK);
        errors++;
        test_done();
    end
endmodule : plsp_top_tb
